// *** logic/rsw_pkg.sv ***
// Purpose: Constants and types for the reset supervisor and watchdog.
// Assumes: 200 MHz timing clock, synchronous active-low reset.
// Notes: Functional notes follow.
// Functional notes
// - Reset output asserts while the manual reset input is low.
// - Manual reset input is debounced so switch bounce gives one reset.
// - A floating manual reset input reads as high and never resets.
// - Power-fail flag is low while the sensed level is below threshold.
// - Kick input idle longer than the timeout drives watchdog expired low.
// - Each kick edge, rising or falling, clears the watchdog counter.
// - Watchdog counter is held clear while reset output is asserted.
// - Every reset trigger yields a reset pulse of at least 200 ms.
// - Reset stays asserted while supply-low is active or manual reset low.
// - Reset holds 200 ms more after supply-low clears or manual reset rises.
// - A watchdog timeout alone never asserts the reset output.
// - Active-high reset output is always the inverse of the active-low one.
// - Watchdog expired stays low until a kick edge or reset clears it.
// - Watchdog expired is forced low while supply-low is active.
// - Watchdog expired returns high at once when supply-low clears.
// - Watchdog timeout period is 1.6 seconds.
// - A new interruption during reset restarts the full 200 ms stretch.
package rsw_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint unsigned RSW_CLK_HZ = 64'd200000000;
  localparam longint unsigned RSW_STRETCH_MS = 64'd200;
  localparam longint unsigned RSW_TIMEOUT_MS = 64'd1600;
  localparam longint unsigned RSW_STRETCH_CYC = RSW_CLK_HZ / 64'd1000 * RSW_STRETCH_MS;
  localparam longint unsigned RSW_TIMEOUT_CYC = RSW_CLK_HZ / 64'd1000 * RSW_TIMEOUT_MS;
  localparam int RSW_CNT_W = 32;
  localparam int RSW_SYNC_STAGES = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RSW_PIN_RST_VAL = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0] {
    RSW_RUN,
    RSW_HOLD
  } rsw_rst_state_type;

  typedef struct packed {
    logic manual_reset_n_in;
    logic supply_low_in;
    logic power_fail_sense_in;
    logic watchdog_kick_in;
  } rsw_pins_type;

  typedef struct packed {
    logic reset_n;
    logic reset;
    logic watchdog_expired_n;
    logic power_fail_flag_n;
  } rsw_outs_type;

  // Outputs leave reset with the processor held and both flags idle high.
  localparam rsw_outs_type RSW_OUTS_RST_VAL = '{reset_n: 1'b0, reset: 1'b1,
    watchdog_expired_n: 1'b1, power_fail_flag_n: 1'b1};

endpackage

// *** logic/rsw_sync.sv ***
// Purpose: Three-stage synchroniser with agreement on the last two stages.
// Assumes: Input is asynchronous to clk_i.
// Notes: First stage feeds only the second stage.
module rsw_sync
  import rsw_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);

  typedef struct packed {
    logic [RSW_SYNC_STAGES-1:0] sh;
    logic q;
  } rsw_sync_state_type;

  rsw_sync_state_type st;
  rsw_sync_state_type next_st;

  always_comb begin
    next_st = st;
    next_st.sh = {st.sh[RSW_SYNC_STAGES-2:0], d_i};
    if (st.sh[RSW_SYNC_STAGES-1] == st.sh[RSW_SYNC_STAGES-2]) begin
      next_st.q = st.sh[RSW_SYNC_STAGES-1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st <= '{sh: {RSW_SYNC_STAGES{RSW_PIN_RST_VAL}}, q: RSW_PIN_RST_VAL};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign q_o = st.q;

endmodule

// *** logic/rsw_top.sv ***
// Purpose: Reset stretcher, independent watchdog and power-fail flag.
// Assumes: Comparator results arrive as digital levels, asynchronous.
// Notes: Pins idle high after reset so a floating manual input stays inactive.
module rsw_top
  import rsw_pkg::*;
#(
  parameter longint unsigned STRETCH_CYC = RSW_STRETCH_CYC,
  parameter longint unsigned TIMEOUT_CYC = RSW_TIMEOUT_CYC
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic manual_reset_n_in_i,
  input wire logic supply_low_i,
  input wire logic power_fail_sense_i,
  input wire logic watchdog_kick_in_i,
  output logic reset_n_o,
  output logic reset_o,
  output logic watchdog_expired_n_o,
  output logic power_fail_flag_n_o
);

  localparam logic [RSW_CNT_W-1:0] STRETCH_LAST = RSW_CNT_W'(STRETCH_CYC - 64'd1);
  localparam logic [RSW_CNT_W-1:0] TIMEOUT_LAST = RSW_CNT_W'(TIMEOUT_CYC - 64'd1);

  // ****************************************
  // Input synchronisers
  // ****************************************
  rsw_pins_type raw;
  rsw_pins_type pin;

  assign raw = '{manual_reset_n_in: manual_reset_n_in_i, supply_low_in: supply_low_i,
                 power_fail_sense_in: power_fail_sense_i, watchdog_kick_in: watchdog_kick_in_i};

  for (genvar g = 0; g < 4; g++) begin : g_sync
    rsw_sync u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .d_i(raw[g]),
      .q_o(pin[g])
    );
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    rsw_rst_state_type mode;
    logic [RSW_CNT_W-1:0] stretch;
    logic [RSW_CNT_W-1:0] wd_cnt;
    logic wd_fired;
    logic kick_prev;
    rsw_outs_type outs;
  } rsw_top_state_type;

  rsw_top_state_type st;
  rsw_top_state_type next_st;

  logic trigger;

  always_comb begin
    next_st = st;
    // Manual input is a level seen after filtering, and the 200 ms stretch masks
    // any bounce, so a bouncing switch merges into one pulse.
    trigger = !pin.manual_reset_n_in || pin.supply_low_in;
    case (st.mode)
      RSW_RUN: begin
        if (trigger) begin
          next_st.mode = RSW_HOLD;
          next_st.stretch = '0;
        end
      end
      RSW_HOLD: begin
        if (trigger) begin
          next_st.stretch = '0;
        end else if (st.stretch >= STRETCH_LAST) begin
          next_st.mode = RSW_RUN;
        end else begin
          next_st.stretch = st.stretch + 1'b1;
        end
      end
      default: begin
        next_st.mode = RSW_HOLD;
        next_st.stretch = '0;
      end
    endcase

    // Watchdog runs independently and never feeds the reset path.
    next_st.kick_prev = pin.watchdog_kick_in;
    if (next_st.mode == RSW_HOLD || trigger) begin
      next_st.wd_cnt = '0;
      next_st.wd_fired = 1'b0;
    end else if (pin.watchdog_kick_in != st.kick_prev) begin
      next_st.wd_cnt = '0;
      next_st.wd_fired = 1'b0;
    end else if (st.wd_cnt >= TIMEOUT_LAST) begin
      next_st.wd_fired = 1'b1;
    end else begin
      next_st.wd_cnt = st.wd_cnt + 1'b1;
    end

    next_st.outs.reset_n = (next_st.mode != RSW_HOLD);
    next_st.outs.reset = (next_st.mode == RSW_HOLD);
    next_st.outs.watchdog_expired_n = !(next_st.wd_fired || pin.supply_low_in);
    next_st.outs.power_fail_flag_n = pin.power_fail_sense_in;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st.mode <= RSW_HOLD;
      st.stretch <= '0;
      st.wd_cnt <= '0;
      st.wd_fired <= 1'b0;
      st.kick_prev <= RSW_PIN_RST_VAL;
      st.outs <= RSW_OUTS_RST_VAL;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign reset_n_o = st.outs.reset_n;
  assign reset_o = st.outs.reset;
  assign watchdog_expired_n_o = st.outs.watchdog_expired_n;
  assign power_fail_flag_n_o = st.outs.power_fail_flag_n;

endmodule

// *** verification/rsw_props.sv ***
// Purpose: Port assertions for the supervisor.
// Assumes: One clock, synchronous active-low reset.
// Notes: Counters track kick idle time and trigger age.
module rsw_props
  import rsw_pkg::*;
#(
  parameter longint unsigned STRETCH_CYC = 20,
  parameter longint unsigned TIMEOUT_CYC = 50
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic manual_reset_n_in_i,
  input wire logic supply_low_i,
  input wire logic power_fail_sense_i,
  input wire logic watchdog_kick_in_i,
  input wire logic reset_n_o,
  input wire logic reset_o,
  input wire logic watchdog_expired_n_o,
  input wire logic power_fail_flag_n_o
);
  logic [31:0] idle;
  logic [31:0] age;
  logic kick_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // The kick edge is seen here four cycles before the synchronised block sees it, inside the 8-cycle slack.
  // Both counters restart while the clock enable is low, since the block is frozen then.
  always_ff @(posedge clk_i) begin
    kick_q <= watchdog_kick_in_i;
    idle <= (!nrst_i || !ce_i || !reset_n_o || kick_q != watchdog_kick_in_i) ? 32'h0 :
      idle + 32'h1;
    age <= (!nrst_i || !ce_i || !manual_reset_n_in_i || supply_low_i) ? 32'h0 : age + 32'h1;
  end
  chk_inverse_out: assert property (reset_o == !reset_n_o)
    else $error("reset outputs differ");
  chk_manual_low: assert property (!manual_reset_n_in_i [*6] |-> !reset_n_o)
    else $error("manual low ignored");
  chk_supply_low: assert property (supply_low_i [*6] |->
    !reset_n_o && !watchdog_expired_n_o)
    else $error("supply low ignored");
  chk_release_time: assert property ($rose(reset_n_o) |->
    age > STRETCH_CYC && age < STRETCH_CYC + 12)
    else $error("release out of time");
  chk_wdog_expire: assert property (idle == TIMEOUT_CYC + 8 |->
    !watchdog_expired_n_o)
    else $error("no timeout");
  chk_wdog_quiet: assert property (idle > 8 && idle < TIMEOUT_CYC - 8 && age > 8
    |-> watchdog_expired_n_o)
    else $error("early timeout");
  chk_pfail_follow: assert property ($stable(power_fail_sense_i) [*6]
    |-> power_fail_flag_n_o == power_fail_sense_i)
    else $error("flag wrong");
  chk_reset_cause: assert property ($fell(reset_n_o) |-> age < 8)
    else $error("reset without trigger");
endmodule

// *** verification/rsw_host.sv ***
// Purpose: Processor model that toggles the kick line.
// Assumes: Kicks only while out of reset and enabled.
// Notes: Each level lasts ten cycles, well above the minimum width.
module rsw_host (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  output logic kick_o = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  always @(posedge clk_i) begin
    cnt <= (!run_i || !reset_n_i || cnt == 9) ? 0 : cnt + 1;
    if (run_i && reset_n_i && cnt == 9) begin
      kick_o <= #1 ~kick_o;
    end
  end
endmodule

// *** verification/rsw_top_tb_top.sv ***
// Purpose: Directed bench for the supervisor.
// Assumes: Short stretch and timeout counts.
// Notes: Kick is the host toggle xor a bench toggle.
module rsw_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam longint unsigned SC = 20;
  localparam longint unsigned TC = 50;
  logic clk_i = 1'b0, nrst_i = 1'b0, mr_n = 1'b1, sup = 1'b0, pfs = 1'b1, tk = 1'b0, run = 1'b0;
  logic hk, rst_n, rst, wdo_n, pfo_n;
  logic ce = 1'b1;
  int err_total = 0, num_checks = 0, n;
  rsw_top #(.STRETCH_CYC(SC), .TIMEOUT_CYC(TC)) u_rsw_top (.clk_i, .nrst_i, .ce_i(ce),
    .manual_reset_n_in_i(mr_n), .supply_low_i(sup), .power_fail_sense_i(pfs),
    .watchdog_kick_in_i(hk ^ tk), .reset_n_o(rst_n), .reset_o(rst),
    .watchdog_expired_n_o(wdo_n), .power_fail_flag_n_o(pfo_n));
  rsw_host u_rsw_host (.clk_i, .reset_n_i(rst_n), .run_i(run), .kick_o(hk));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %b exp %b", $time, got, exp);
    end
  endtask
  // Bounded wait for release, returning the cycles spent.
  task automatic rel_in;
    n = 0;
    while (rst_n !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk(n >= SC && n <= SC + 8, 1'b1);
  endtask
  task automatic close_out;
    $display("counts: checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic t_start;
    cyc(16);
    chk(rst, 1'b1);
    nrst_i = 1;
    rel_in();
    chk(rst, 1'b0);
    $display("test start done");
  endtask
  task automatic t_power;
    for (int v = 0; v < 2; v++) begin
      pfs = v[0];
      cyc(6);
      chk(pfo_n, v[0]);
    end
    $display("test power done");
  endtask
  task automatic t_manual;
    mr_n = 0;
    cyc(1);
    mr_n = 1;
    cyc(1);
    mr_n = 0;
    cyc(8);
    chk(rst_n, 1'b0);
    chk(rst, 1'b1);
    mr_n = 1;
    cyc(1);
    mr_n = 0;
    cyc(1);
    mr_n = 1;
    rel_in();
    cyc(10);
    chk(rst_n, 1'b1);
    $display("test manual done");
  endtask
  task automatic t_supply;
    sup = 1;
    cyc(8);
    chk(rst_n, 1'b0);
    chk(wdo_n, 1'b0);
    sup = 0;
    cyc(7);
    chk(wdo_n, 1'b1);
    chk(rst_n, 1'b0);
    sup = 1;
    cyc(3);
    sup = 0;
    rel_in();
    $display("test supply done");
  endtask
  task automatic t_watchdog;
    mr_n = 0;
    tk = 1;
    cyc(8);
    mr_n = 1;
    rel_in();
    cyc(TC - 10);
    chk(wdo_n, 1'b1);
    cyc(20);
    chk(wdo_n, 1'b0);
    chk(rst_n, 1'b1);
    tk = 0;
    cyc(6);
    chk(wdo_n, 1'b1);
    run = 1;
    cyc(3 * TC);
    chk(wdo_n, 1'b1);
    run = 0;
    $display("test watchdog done");
  endtask
  // A kick seen while frozen must wait for the enable, and both resets clear a timeout.
  task automatic t_hold;
    cyc(TC + 10);
    chk(wdo_n, 1'b0);
    ce = 0;
    tk = ~tk;
    cyc(10);
    chk(wdo_n, 1'b0);
    ce = 1;
    cyc(8);
    chk(wdo_n, 1'b1);
    cyc(TC + 10);
    chk(wdo_n, 1'b0);
    mr_n = 0;
    cyc(8);
    chk(wdo_n, 1'b1);
    chk(rst_n, 1'b0);
    mr_n = 1;
    rel_in();
    cyc(TC + 10);
    chk(wdo_n, 1'b0);
    nrst_i = 0;
    cyc(2);
    chk(wdo_n, 1'b1);
    chk(rst, 1'b1);
    nrst_i = 1;
    rel_in();
    chk(rst, 1'b0);
    $display("test hold done");
  endtask
  initial begin
    t_start();
    t_power();
    t_manual();
    t_supply();
    t_watchdog();
    t_hold();
    close_out();
  end
  initial begin
    #20us;
    err_total++;
    close_out();
  end
endmodule
bind rsw_top rsw_props #(.STRETCH_CYC(STRETCH_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) u_rsw_props (
  .clk_i, .nrst_i, .ce_i, .manual_reset_n_in_i, .supply_low_i, .power_fail_sense_i,
  .watchdog_kick_in_i, .reset_n_o, .reset_o, .watchdog_expired_n_o, .power_fail_flag_n_o);
